/* rtl/wwd_pkg.sv */
// shared constants, register map and state types of the window watchdog gating block
package wwd_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DP_TIME_NS = 100000;
  localparam int TR_TIME_NS = 1000000;
  localparam int HOLD_TIME_NS = 500000;
  // a longest time rounds down, and never below one cycle
  localparam int DP_CYCLES = (DP_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (DP_TIME_NS / CLK_PERIOD_NS);
  localparam int TR_CYCLES = (TR_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (TR_TIME_NS / CLK_PERIOD_NS);
  localparam int HOLD_CYCLES = (HOLD_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                               (HOLD_TIME_NS / CLK_PERIOD_NS);

  // widths
  localparam int CNT_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TRIG_CNT_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DP_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TR_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HOLD_COUNT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // control fields
  localparam int CTRL_ENABLE_PIN_VARIANT = 0;
  localparam int CTRL_CURRENT_GATE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MONITOR = 2;
  localparam int ST_CURRENT_ACT = 3;
  localparam int ST_FAULT_OUT = 4;
  localparam int ST_CAUSE_TIMEOUT = 5;
  localparam int ST_CAUSE_DOUBLE = 6;
  localparam int ST_TRIG_CNT_LSB = 8;

  // synchronised pin bundle
  typedef struct packed {
    logic trigger_input;
    logic adjust_tied_low;
    logic adjust_tied_high;
    logic enable_input;
    logic current_above_act;
    logic current_below_deact;
    logic supply_input_ok;
    logic regulated_supply_ok;
    logic reset_output_n;
  } wwd_pins_t;

  localparam int PINS_W = $bits(wwd_pins_t);

  typedef enum logic [1:0] {
    WWD_OFF,
    WWD_OPEN,
    WWD_CLOSED,
    WWD_FAULT
  } wwd_fsm_t;

  typedef struct packed {
    wwd_fsm_t fsm;
    logic [CNT_W-1:0] tr_cnt;
    logic [CNT_W-1:0] win_cnt;
    logic cur_act;
    logic trig_prev;
    logic fault_n;
    logic merged_n;
    logic cause_timeout;
    logic cause_double;
    logic [TRIG_CNT_W-1:0] trig_cnt;
    logic [1:0] ctrl;
    logic [CNT_W-1:0] dp_lim;
    logic [CNT_W-1:0] tr_lim;
    logic [CNT_W-1:0] hold_lim;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } wwd_state_t;

endpackage

/* rtl/wwd_sync.sv */
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module wwd_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } wwd_sync_state_t;

  wwd_sync_state_t s_reg;
  wwd_sync_state_t s_next;

  always_comb begin
    s_next.meta = async_in;
    s_next.sync = s_reg.meta;
  end

  // both stages clear to low, so a floating trigger sits low and yields no edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.sync;

endmodule // wwd_sync
`default_nettype wire

/* rtl/wwd_top.sv */
// window watchdog gating, trigger input and fault output with an apb register slave
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
  parameter logic [wwd_pkg::CNT_W-1:0] DP_CYCLES = wwd_pkg::CNT_W'(wwd_pkg::DP_CYCLES),
  parameter logic [wwd_pkg::CNT_W-1:0] TR_CYCLES = wwd_pkg::CNT_W'(wwd_pkg::TR_CYCLES),
  parameter logic [wwd_pkg::CNT_W-1:0] HOLD_CYCLES = wwd_pkg::CNT_W'(wwd_pkg::HOLD_CYCLES)
) (
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wwd_pkg::ADDR_W-1:0] paddr,
  input wire logic [wwd_pkg::DATA_W-1:0] pwdata,
  output logic [wwd_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, inputs all asynchronous to clock
  input wire logic trigger_input,
  input wire logic adjust_tied_low,
  input wire logic adjust_tied_high,
  input wire logic enable_input,
  input wire logic current_above_act,
  input wire logic current_below_deact,
  input wire logic supply_input_ok,
  input wire logic regulated_supply_ok,
  input wire logic reset_output_n,
  output logic watchdog_fault_output_n,
  output logic merged_fault_output_n,
  output logic monitor_active
);

  wwd_pkg::wwd_pins_t pins_async;
  wwd_pkg::wwd_pins_t pins;
  wwd_pkg::wwd_state_t s_reg;
  wwd_pkg::wwd_state_t s_next;

  logic mon;
  logic trig_rise;
  logic trig_ok;
  logic cur_act_next;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [wwd_pkg::DATA_W-1:0] rd_mux;

  // a limit of zero acts as one cycle, so every window has some length
  function automatic logic expired(input logic [wwd_pkg::CNT_W-1:0] cnt,
                                   input logic [wwd_pkg::CNT_W-1:0] lim);
    logic [wwd_pkg::CNT_W-1:0] last;
    last = (lim == '0) ? '0 : lim - 1'b1;
    return cnt >= last;
  endfunction

  function automatic logic [wwd_pkg::CNT_W-1:0] bump(input logic [wwd_pkg::CNT_W-1:0] cnt);
    return (cnt == '1) ? cnt : cnt + 1'b1;
  endfunction

  function automatic logic known_addr(input logic [wwd_pkg::ADDR_W-1:0] a);
    return (a == wwd_pkg::OFS_CTRL) || (a == wwd_pkg::OFS_DP_COUNT) ||
           (a == wwd_pkg::OFS_TR_COUNT) || (a == wwd_pkg::OFS_HOLD_COUNT) ||
           (a == wwd_pkg::OFS_STATUS);
  endfunction

  assign pins_async.trigger_input = trigger_input;
  assign pins_async.adjust_tied_low = adjust_tied_low;
  assign pins_async.adjust_tied_high = adjust_tied_high;
  assign pins_async.enable_input = enable_input;
  assign pins_async.current_above_act = current_above_act;
  assign pins_async.current_below_deact = current_below_deact;
  assign pins_async.supply_input_ok = supply_input_ok;
  assign pins_async.regulated_supply_ok = regulated_supply_ok;
  assign pins_async.reset_output_n = reset_output_n;

  // every pin passes two flops; the chain resets low like a pull-down
  wwd_sync #(
    .W(wwd_pkg::PINS_W)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in(pins_async),
    .sync_out(pins)
  );

  // current hysteresis latch: the band between thresholds holds the last decision
  always_comb begin
    cur_act_next = s_reg.cur_act;
    if (!pins.supply_input_ok) begin
      cur_act_next = 1'b0;
    end else if (s_reg.ctrl[wwd_pkg::CTRL_ENABLE_PIN_VARIANT] && !pins.enable_input) begin
      cur_act_next = 1'b0; // detection also stops while disabled
    end else if (pins.current_above_act) begin
      cur_act_next = 1'b1;
    end else if (pins.current_below_deact) begin
      cur_act_next = 1'b0;
    end
  end

  // monitoring gate
  always_comb begin
    mon = 1'b0;
    if (!pins.regulated_supply_ok) begin
      mon = 1'b0;
    end else if (s_reg.ctrl[wwd_pkg::CTRL_ENABLE_PIN_VARIANT]) begin
      mon = pins.enable_input &&
            (s_reg.cur_act || !s_reg.ctrl[wwd_pkg::CTRL_CURRENT_GATE]);
    end else if (pins.adjust_tied_low) begin
      mon = 1'b0;
    end else if (pins.adjust_tied_high) begin
      mon = 1'b1;
    end else begin
      mon = s_reg.cur_act;
    end
  end

  assign trig_rise = pins.trigger_input && !s_reg.trig_prev;
  assign trig_ok = trig_rise && mon && s_reg.fault_n &&
                   ((s_reg.fsm == wwd_pkg::WWD_OPEN) || (s_reg.fsm == wwd_pkg::WWD_CLOSED));

  // apb: read data is caught in the setup cycle so the access phase needs no wait
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign addr_ok = known_addr(paddr);

  always_comb begin
    rd_mux = '0;
    case (paddr)
      wwd_pkg::OFS_CTRL: begin
        rd_mux[1:0] = s_reg.ctrl;
      end
      wwd_pkg::OFS_DP_COUNT: begin
        rd_mux[wwd_pkg::CNT_W-1:0] = s_reg.dp_lim;
      end
      wwd_pkg::OFS_TR_COUNT: begin
        rd_mux[wwd_pkg::CNT_W-1:0] = s_reg.tr_lim;
      end
      wwd_pkg::OFS_HOLD_COUNT: begin
        rd_mux[wwd_pkg::CNT_W-1:0] = s_reg.hold_lim;
      end
      wwd_pkg::OFS_STATUS: begin
        rd_mux[wwd_pkg::ST_STATE_LSB +: 2] = s_reg.fsm;
        rd_mux[wwd_pkg::ST_MONITOR] = mon;
        rd_mux[wwd_pkg::ST_CURRENT_ACT] = s_reg.cur_act;
        rd_mux[wwd_pkg::ST_FAULT_OUT] = s_reg.fault_n;
        rd_mux[wwd_pkg::ST_CAUSE_TIMEOUT] = s_reg.cause_timeout;
        rd_mux[wwd_pkg::ST_CAUSE_DOUBLE] = s_reg.cause_double;
        rd_mux[wwd_pkg::ST_TRIG_CNT_LSB +: wwd_pkg::TRIG_CNT_W] = s_reg.trig_cnt;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.cur_act = cur_act_next;
    s_next.trig_prev = pins.trigger_input;

    // register writes take effect at the access edge
    if (wr_en) begin
      case (paddr)
        wwd_pkg::OFS_CTRL: begin
          s_next.ctrl = pwdata[1:0];
        end
        wwd_pkg::OFS_DP_COUNT: begin
          s_next.dp_lim = pwdata[wwd_pkg::CNT_W-1:0];
        end
        wwd_pkg::OFS_TR_COUNT: begin
          s_next.tr_lim = pwdata[wwd_pkg::CNT_W-1:0];
        end
        wwd_pkg::OFS_HOLD_COUNT: begin
          s_next.hold_lim = pwdata[wwd_pkg::CNT_W-1:0];
        end
        default: begin
          s_next.ctrl = s_reg.ctrl;
        end
      endcase
    end
    if (psel && !penable) begin
      s_next.prdata = rd_setup ? rd_mux : '0;
      s_next.pslverr = !addr_ok;
    end

    // window state machine
    case (s_reg.fsm)
      wwd_pkg::WWD_OFF: begin
        s_next.tr_cnt = '0;
        s_next.win_cnt = '0;
        if (mon) begin
          s_next.fsm = wwd_pkg::WWD_OPEN;
        end
      end
      wwd_pkg::WWD_OPEN: begin
        if (!mon) begin
          // deactivation with output high drops the elapsed time
          s_next.fsm = wwd_pkg::WWD_OFF;
          s_next.tr_cnt = '0;
          s_next.win_cnt = '0;
        end else if (trig_ok) begin
          s_next.fsm = wwd_pkg::WWD_CLOSED;
          s_next.tr_cnt = '0;
          s_next.win_cnt = '0;
          s_next.trig_cnt = s_reg.trig_cnt + 1'b1;
        end else if (expired(s_reg.tr_cnt, s_reg.tr_lim)) begin
          s_next.fsm = wwd_pkg::WWD_FAULT;
          s_next.win_cnt = '0;
          s_next.cause_timeout = 1'b1;
          s_next.cause_double = 1'b0;
        end else begin
          s_next.tr_cnt = bump(s_reg.tr_cnt);
        end
      end
      wwd_pkg::WWD_CLOSED: begin
        if (!mon) begin
          s_next.fsm = wwd_pkg::WWD_OFF;
          s_next.tr_cnt = '0;
          s_next.win_cnt = '0;
        end else if (trig_ok) begin
          s_next.fsm = wwd_pkg::WWD_FAULT;
          s_next.win_cnt = '0;
          s_next.trig_cnt = s_reg.trig_cnt + 1'b1;
          s_next.cause_timeout = 1'b0;
          s_next.cause_double = 1'b1;
        end else if (expired(s_reg.win_cnt, s_reg.dp_lim)) begin
          s_next.fsm = wwd_pkg::WWD_OPEN;
          s_next.win_cnt = '0;
          s_next.tr_cnt = bump(s_reg.tr_cnt);
        end else begin
          s_next.win_cnt = bump(s_reg.win_cnt);
          s_next.tr_cnt = bump(s_reg.tr_cnt);
        end
      end
      wwd_pkg::WWD_FAULT: begin
        // the hold runs to its end even when monitoring drops meanwhile, unless regulated_supply_ok falls and forces WWD_OFF
        if (expired(s_reg.win_cnt, s_reg.hold_lim)) begin
          s_next.fsm = mon ? wwd_pkg::WWD_OPEN : wwd_pkg::WWD_OFF;
          s_next.win_cnt = '0;
          s_next.tr_cnt = '0;
        end else begin
          s_next.win_cnt = bump(s_reg.win_cnt);
        end
      end
      default: begin
        s_next.fsm = wwd_pkg::WWD_OFF;
      end
    endcase

    // supply below detection puts the timer back to its initial state
    if (!pins.regulated_supply_ok) begin
      s_next.fsm = wwd_pkg::WWD_OFF;
      s_next.tr_cnt = '0;
      s_next.win_cnt = '0;
    end

    s_next.fault_n = (s_next.fsm != wwd_pkg::WWD_FAULT);
    s_next.merged_n = s_next.fault_n && pins.reset_output_n;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg.fsm <= wwd_pkg::WWD_OFF;
      s_reg.tr_cnt <= '0;
      s_reg.win_cnt <= '0;
      s_reg.cur_act <= 1'b0;
      s_reg.trig_prev <= 1'b0;
      s_reg.fault_n <= 1'b1;
      s_reg.merged_n <= 1'b0;
      s_reg.cause_timeout <= 1'b0;
      s_reg.cause_double <= 1'b0;
      s_reg.trig_cnt <= '0;
      s_reg.ctrl <= wwd_pkg::CTRL_RESET;
      s_reg.dp_lim <= DP_CYCLES;
      s_reg.tr_lim <= TR_CYCLES;
      s_reg.hold_lim <= HOLD_CYCLES;
      s_reg.prdata <= '0;
      s_reg.pslverr <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && s_reg.pslverr;
  assign watchdog_fault_output_n = s_reg.fault_n;
  assign merged_fault_output_n = s_reg.merged_n;
  assign monitor_active = mon;

endmodule // wwd_top
`default_nettype wire

/* verification/wwd_top_properties.sv */
// port checker of the window watchdog gating block
`timescale 1ns/1ps
`default_nettype none
module wwd_top_properties #(
  parameter logic [wwd_pkg::CNT_W-1:0] TR_CYCLES = 40,
  parameter logic [wwd_pkg::CNT_W-1:0] HOLD_CYCLES = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic trigger_input,
  input wire logic reset_output_n,
  input wire logic regulated_supply_ok,
  input wire logic watchdog_fault_output_n,
  input wire logic merged_fault_output_n,
  input wire logic monitor_active
);
  logic [31:0] idle_cnt;
  logic [31:0] low_cnt;
  logic trig_q;
  logic brk;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // brk marks a hold cut short by supply loss, whose length is not the full hold
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= '0;
      low_cnt <= '0;
      trig_q <= 1'b0;
      brk <= 1'b1;
    end else begin
      trig_q <= trigger_input;
      idle_cnt <= (!monitor_active || !watchdog_fault_output_n || (trigger_input && !trig_q)) ?
                  '0 : idle_cnt + 1;
      low_cnt <= watchdog_fault_output_n ? '0 : low_cnt + 1;
      brk <= watchdog_fault_output_n ? 1'b0 : (brk || !regulated_supply_ok);
    end
  end
  property p_merged_fault; !watchdog_fault_output_n |-> ##[0:1] !merged_fault_output_n; endproperty
  property p_merged_reset; !reset_output_n [*4] |-> !merged_fault_output_n; endproperty
  property p_merged_high;
    (watchdog_fault_output_n && reset_output_n) [*5] |-> merged_fault_output_n;
  endproperty
  property p_supply_off; !regulated_supply_ok [*3] |-> !monitor_active; endproperty
  property p_supply_clear; !regulated_supply_ok [*5] |-> watchdog_fault_output_n; endproperty
  property p_fault_cause;
    $fell(watchdog_fault_output_n) |-> $past(monitor_active) || $past(monitor_active, 2);
  endproperty
  property p_timeout; idle_cnt <= TR_CYCLES + 8; endproperty
  property p_hold;
    $rose(watchdog_fault_output_n) && !brk |-> low_cnt >= HOLD_CYCLES - 1 && low_cnt <= HOLD_CYCLES + 1;
  endproperty
  a_merged_fault: assert property (p_merged_fault)
    else $error("merged output high in fault");
  a_merged_reset: assert property (p_merged_reset)
    else $error("merged output high in reset");
  a_merged_high: assert property (p_merged_high)
    else $error("merged output low with both high");
  a_supply_off: assert property (p_supply_off)
    else $error("monitoring with supply low");
  a_supply_clear: assert property (p_supply_clear)
    else $error("fault output low with supply low");
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault raised while not monitoring");
  a_timeout: assert property (p_timeout)
    else $error("trigger timeout missed");
  a_hold: assert property (p_hold)
    else $error("fault hold length wrong");
  c_fault: cover property ($fell(watchdog_fault_output_n));
  c_hold_end: cover property ($rose(watchdog_fault_output_n));
  c_monitor: cover property ($rose(monitor_active));
endmodule // wwd_top_properties
bind wwd_top wwd_top_properties #(.TR_CYCLES(TR_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) i_props (
  .clock(clock), .resetn(resetn), .trigger_input(trigger_input), .reset_output_n(reset_output_n),
  .regulated_supply_ok(regulated_supply_ok), .watchdog_fault_output_n(watchdog_fault_output_n),
  .merged_fault_output_n(merged_fault_output_n), .monitor_active(monitor_active));
`default_nettype wire

/* verification/wwd_mcu_model.sv */
// model of the monitored processor that sends trigger pulses
`timescale 1ns/1ps
`default_nettype none
module wwd_mcu_model (
  input wire logic clock,
  output logic trigger_input
);
  // a quiet processor leaves the pin at its pull-down level, so no edge
  initial trigger_input = 1'b0;
  // pulses shorter than one cycle would be lost in the synchroniser
  task automatic send(input int hi, input int lo);
    @(posedge clock);
    trigger_input <= 1'b1;
    repeat (hi) @(posedge clock);
    trigger_input <= 1'b0;
    repeat (lo) @(posedge clock);
  endtask
endmodule // wwd_mcu_model
`default_nettype wire

/* verification/wwd_top_bench.sv */
// self-checking bench of the window watchdog gating block
`timescale 1ns/1ps
`default_nettype none
module wwd_top_bench;
  localparam logic [23:0] DP = 24'h00000c;
  localparam logic [23:0] TR = 24'h00003c;
  localparam logic [23:0] HOLD = 24'h000020;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, erv, trigger_input, pready, pslverr;
  logic adjust_tied_low, adjust_tied_high, enable_input, current_above_act;
  logic current_below_deact, supply_input_ok, regulated_supply_ok, reset_output_n;
  logic watchdog_fault_output_n, merged_fault_output_n, monitor_active;
  logic [7:0] paddr;
  logic [7:0] cnt_a;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0] ofs [3] = '{wwd_pkg::OFS_DP_COUNT, wwd_pkg::OFS_TR_COUNT, wwd_pkg::OFS_HOLD_COUNT};
  logic [23:0] cnts [3] = '{DP, TR, HOLD};
  // {tied low, tied high, above act, below deact, expected gate}
  logic [4:0] rows [8] = '{5'h14, 5'h1c, 5'h0b, 5'h05, 5'h01, 5'h02, 5'h00, 5'h05};
  int checked = 0;
  int n_errors = 0;
  int cycles = 0;
  wwd_top #(.DP_CYCLES(DP), .TR_CYCLES(TR), .HOLD_CYCLES(HOLD)) i_dut (.clock, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_input,
    .adjust_tied_low, .adjust_tied_high, .enable_input, .current_above_act, .current_below_deact,
    .supply_input_ok, .regulated_supply_ok, .reset_output_n, .watchdog_fault_output_n,
    .merged_fault_output_n, .monitor_active);
  wwd_mcu_model i_mcu (.clock, .trigger_input);
  always #5 clock = ~clock;
  task automatic results;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pins go through two synchroniser flops, so four edges is settled
  task automatic gate(input logic [3:0] p);
    @(posedge clock);
    {adjust_tied_low, adjust_tied_high, current_above_act, current_below_deact} <= p;
    repeat (4) @(posedge clock);
  endtask
  task automatic wait_fault(input logic lvl, input int lim);
    int i;
    i = 0;
    @(negedge clock);
    while (watchdog_fault_output_n !== lvl && i < lim) begin
      @(negedge clock);
      i++;
    end
    check("fault level", 32'(watchdog_fault_output_n), 32'(lvl));
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {adjust_tied_low, adjust_tied_high, enable_input, current_above_act} = 4'h0;
    {current_below_deact, supply_input_ok, regulated_supply_ok, reset_output_n} = 4'hf;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    foreach (ofs[k]) begin
      apb(1'b1, ofs[k], 32'hff000000 | 32'(cnts[k]));
      apb(1'b0, ofs[k], 32'h0);
      check("count", rdv, 32'(cnts[k]));
    end
    apb(1'b1, 8'h14, 32'h1);
    check("unmapped err", 32'(erv), 32'h1);
    foreach (rows[k]) begin
      gate(rows[k][4:1]);
      check("gate", 32'(monitor_active), 32'(rows[k][0]));
    end
    supply_input_ok <= 1'b0;
    gate(4'h2);
    check("low input", 32'(monitor_active), 32'h0);
    supply_input_ok <= 1'b1;
    gate(4'h2);
    check("input back", 32'(monitor_active), 32'h1);
    apb(1'b1, wwd_pkg::OFS_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      enable_input <= k[0];
      gate(4'h1);
      check("enable", 32'(monitor_active), 32'(k[0]));
    end
    // enable variant that also asks for load current: enable alone must not open the gate
    apb(1'b1, wwd_pkg::OFS_CTRL, 32'h3);
    enable_input <= 1'b1;
    gate(4'h1);
    check("enable low current", 32'(monitor_active), 32'h0);
    gate(4'h2);
    check("enable with current", 32'(monitor_active), 32'h1);
    apb(1'b1, wwd_pkg::OFS_CTRL, 32'h0);
    regulated_supply_ok <= 1'b0;
    gate(4'h4);
    check("supply low", 32'(monitor_active), 32'h0);
    regulated_supply_ok <= 1'b1;
    gate(4'h4);
    apb(1'b0, wwd_pkg::OFS_STATUS, 32'h0);
    cnt_a = rdv[wwd_pkg::ST_TRIG_CNT_LSB +: 8];
    repeat (3) i_mcu.send(3, int'(DP) + 6);
    check("no fault", 32'(watchdog_fault_output_n), 32'h1);
    apb(1'b0, wwd_pkg::OFS_STATUS, 32'h0);
    check("triggers", 32'(rdv[wwd_pkg::ST_TRIG_CNT_LSB +: 8]), 32'(cnt_a + 8'h3));
    i_mcu.send(3, 3);
    i_mcu.send(3, 3);
    wait_fault(1'b0, 8);
    apb(1'b0, wwd_pkg::OFS_STATUS, 32'h0);
    check("double", 32'(rdv[wwd_pkg::ST_CAUSE_DOUBLE]), 32'h1);
    cnt_a = rdv[wwd_pkg::ST_TRIG_CNT_LSB +: 8];
    i_mcu.send(3, 3);
    gate(4'h8);
    check("fault held", 32'(watchdog_fault_output_n), 32'h0);
    apb(1'b0, wwd_pkg::OFS_STATUS, 32'h0);
    check("ignored", 32'(rdv[wwd_pkg::ST_TRIG_CNT_LSB +: 8]), 32'(cnt_a));
    wait_fault(1'b1, 40);
    gate(4'h4);
    wait_fault(1'b0, int'(TR) + 20);
    @(negedge clock);
    check("merged fault", 32'(merged_fault_output_n), 32'h0);
    apb(1'b0, wwd_pkg::OFS_STATUS, 32'h0);
    check("timeout", 32'(rdv[wwd_pkg::ST_CAUSE_TIMEOUT]), 32'h1);
    wait_fault(1'b1, 40);
    @(posedge clock);
    reset_output_n <= 1'b0;
    repeat (5) @(negedge clock);
    check("merged reset", 32'(merged_fault_output_n), 32'h0);
    @(posedge clock);
    reset_output_n <= 1'b1;
    repeat (5) @(negedge clock);
    check("merged high", 32'(merged_fault_output_n), 32'h1);
    results();
  end
endmodule // wwd_top_bench
`default_nettype wire
